// ---- include/desc_if.sv ----
/*
  descriptor stream carrier between the classifier stage and the buffer.
  assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface desc_if;
  logic           valid;
  logic           ready;
  qos_pkg::desc_t data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : desc_if

// ---- include/qos_pkg.sv ----
/*
  constants, types and mapping functions for the qos priority mapper and policer.
  assumes one clock, synchronous active-high reset, descriptors from same-clock logic.
*/
// Overview of operation
// - service octet holds a six-bit code point above two unused bits
// - top three code point bits act as the legacy precedence value
// - precedence is three bits giving classes 0 to 7, 7 highest
// - auto queue assigned only to unclassified packets while qos is on
// - user priority 1 to queue 0, 2 to 1, 0 to 2, others same
// - precedence 1..7 map to queues 3,4,5,6,6,7,7
// - length over 1100 queue 2, 250 to 1100 queue 3, under 250 queue 5
// - under congestion, packets of queues below the floor are discarded
// - credit counts bytes and is capped at the bucket size
// - tokens added at a constant configured rate, never above size
// - send only when tokens cover the length, else stall
// - a sent packet debits its length from the bucket
// - shaping holds a short-credit packet until tokens suffice
// - policing drops or remarks the code point of a short-credit packet
// - markers tag green, yellow or red loss priority
// - single-rate fills committed bucket, overflow spills into excess bucket
// - single-rate green when committed credit covers length, then debit it
// - else yellow if excess suffices, otherwise red; drop consumes nothing
// - two-rate fills committed and peak buckets at their own rates
// - two-rate red when peak credit is short; red consumes nothing
// - two-rate green if committed also suffices, else yellow
package qos_pkg;

  localparam int LEN_W  = 16;
  localparam int TOK_W  = 24;
  localparam int RATE_W = 16;
  localparam int Q_W    = 3;

  localparam logic [LEN_W-1:0] LEN_LONG  = 16'h044c;
  localparam logic [LEN_W-1:0] LEN_SHORT = 16'h00fa;

  localparam logic [Q_W-1:0] Q_PREC0_DEF = 3'h2;
  localparam logic [Q_W-1:0] Q_PREC0_ALT = 3'h0;
  localparam logic [Q_W-1:0] Q_LEN_LONG  = 3'h2;
  localparam logic [Q_W-1:0] Q_LEN_MID   = 3'h3;
  localparam logic [Q_W-1:0] Q_LEN_SHORT = 3'h5;

  localparam int DSCP_LSB = 2;
  localparam int PREC_LSB = 3;

  localparam logic [TOK_W-1:0] TOK_RST = 24'h000000;

  typedef enum logic [1:0] {COL_GREEN, COL_YELLOW, COL_RED} color_t;
  typedef enum logic [1:0] {MTR_OFF, MTR_TB, MTR_SRTCM, MTR_TRTCM} meter_t;
  typedef enum logic [1:0] {SRC_L2, SRC_L3, SRC_LEN} src_t;
  typedef enum logic {ST_IDLE, ST_EVAL} hold_st_t;

  typedef struct packed {
    logic [Q_W-1:0]   queue;
    color_t           color;
    logic [5:0]       dscp;
    logic [LEN_W-1:0] len;
  } desc_t;

  function automatic logic [Q_W-1:0] l2_queue(input logic [2:0] upri);
    case (upri)
      3'h0:    l2_queue = 3'h2;
      3'h1:    l2_queue = 3'h0;
      3'h2:    l2_queue = 3'h1;
      default: l2_queue = upri;
    endcase
  endfunction : l2_queue

  function automatic logic [Q_W-1:0] l3_queue(input logic [2:0] prec,
                                               input logic [Q_W-1:0] p0q);
    case (prec)
      3'h0:    l3_queue = p0q;
      3'h1:    l3_queue = 3'h3;
      3'h2:    l3_queue = 3'h4;
      3'h3:    l3_queue = 3'h5;
      3'h4:    l3_queue = 3'h6;
      3'h5:    l3_queue = 3'h6;
      default: l3_queue = 3'h7;
    endcase
  endfunction : l3_queue

  function automatic logic [Q_W-1:0] len_queue(input logic [LEN_W-1:0] len);
    if (len > LEN_LONG)
      len_queue = Q_LEN_LONG;
    else if (len >= LEN_SHORT)
      len_queue = Q_LEN_MID;
    else
      len_queue = Q_LEN_SHORT;
  endfunction : len_queue

  function automatic logic [TOK_W-1:0] fill(input logic [TOK_W-1:0] cnt,
                                            input logic [TOK_W-1:0] inc,
                                            input logic [TOK_W-1:0] size);
    logic [TOK_W:0] s;
    s = {1'b0, cnt} + {1'b0, inc};
    if (s > {1'b0, size})
      fill = size;
    else
      fill = s[TOK_W-1:0];
  endfunction : fill

endpackage : qos_pkg

// ---- rtl/desc_buf.sv ----
/*
  two-entry skid buffer on the decided-descriptor path.
  assumes the downstream ready may drop at any cycle; no word is lost.
*/
`timescale 1ns/1ps
module desc_buf (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_ce,
  desc_if.snk       up,
  desc_if.src       dn
);
  logic           main_v_q;
  logic           skid_v_q;
  qos_pkg::desc_t main_q;
  qos_pkg::desc_t skid_q;
  wire            take = up.valid & ~skid_v_q;
  wire            pop  = main_v_q & dn.ready;
  wire            adv  = ~main_v_q | pop;

  assign up.ready = ~skid_v_q;
  assign dn.valid = main_v_q;
  assign dn.data  = main_q;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      main_v_q <= 1'b0;
      skid_v_q <= 1'b0;
    end
    else if (i_ce)
    begin
      if (adv)
      begin
        main_v_q <= skid_v_q | take;
        skid_v_q <= 1'b0;
      end
      else if (take)
        skid_v_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_ce && adv)
      main_q <= skid_v_q ? skid_q : up.data;
    if (i_ce && !adv && take)
      skid_q <= up.data;
  end

endmodule : desc_buf

// ---- rtl/qos_priority_mapper_policer.sv ----
/*
  qos datapath: queue mapping for unclassified packets, token bucket and
  three-colour metering, discard on congestion, skid buffer to the scheduler.
  assumes descriptors and configuration come from logic on i_clk.
*/
`timescale 1ns/1ps
module qos_priority_mapper_policer (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst,
  input  wire logic                       i_ce,
  input  wire logic                       i_in_valid,
  output logic                            o_in_ready,
  input  wire logic [qos_pkg::LEN_W-1:0]  i_in_len,
  input  wire logic [2:0]                 i_in_upri,
  input  wire logic [7:0]                 i_in_tos,
  input  wire logic                       i_in_class_hit,
  input  wire logic [qos_pkg::Q_W-1:0]    i_in_class_queue,
  input  wire logic                       i_qos_en,
  input  wire logic [1:0]                 i_auto_src,
  input  wire logic                       i_prec0_alt,
  input  wire logic [1:0]                 i_meter_mode,
  input  wire logic                       i_police,
  input  wire logic                       i_red_drop,
  input  wire logic [5:0]                 i_remark_dscp,
  input  wire logic [qos_pkg::RATE_W-1:0] i_cir_inc,
  input  wire logic [qos_pkg::RATE_W-1:0] i_pir_inc,
  input  wire logic [qos_pkg::TOK_W-1:0]  i_cbs,
  input  wire logic [qos_pkg::TOK_W-1:0]  i_xbs,
  input  wire logic                       i_congested,
  input  wire logic [qos_pkg::Q_W-1:0]    i_congest_floor,
  output logic                            o_out_valid,
  input  wire logic                       i_out_ready,
  output logic [qos_pkg::Q_W-1:0]         o_out_queue,
  output logic [1:0]                      o_out_color,
  output logic [5:0]                      o_out_dscp,
  output logic [qos_pkg::LEN_W-1:0]       o_out_len,
  output logic                            o_drop,
  output logic                            o_wait,
  output logic [qos_pkg::TOK_W-1:0]       o_tc_tokens,
  output logic [qos_pkg::TOK_W-1:0]       o_te_tokens
);

  // held descriptor
  qos_pkg::hold_st_t             st_q;
  qos_pkg::hold_st_t             st_d;
  logic                          rdy_q;
  logic [qos_pkg::LEN_W-1:0]     len_q;
  logic [2:0]                    upri_q;
  logic [7:0]                    tos_q;
  logic                          hit_q;
  logic [qos_pkg::Q_W-1:0]       cq_q;

  // token state
  logic [qos_pkg::TOK_W-1:0]     tc_q;
  logic [qos_pkg::TOK_W-1:0]     te_q;
  logic [qos_pkg::TOK_W-1:0]     tc_d;
  logic [qos_pkg::TOK_W-1:0]     te_d;
  logic                          drop_q;
  logic                          wait_q;

  // decision
  qos_pkg::color_t               color;
  logic                          wait_tok;
  logic                          drop;
  logic                          deb_c;
  logic                          deb_e;
  logic                          remark;

  desc_if up_if ();
  desc_if dn_if ();

  wire qos_pkg::meter_t mode = qos_pkg::meter_t'(i_meter_mode);
  wire qos_pkg::src_t   src  = qos_pkg::src_t'(i_auto_src);
  wire                  eval = (st_q == qos_pkg::ST_EVAL);
  wire                  accept = i_in_valid & rdy_q;

  wire [5:0] dscp = tos_q[7:qos_pkg::DSCP_LSB];
  wire [2:0] prec = dscp[5:qos_pkg::PREC_LSB];

  wire [qos_pkg::Q_W-1:0] p0q = i_prec0_alt ? qos_pkg::Q_PREC0_ALT
                                            : qos_pkg::Q_PREC0_DEF;
  wire [qos_pkg::Q_W-1:0] q_l2  = qos_pkg::l2_queue(upri_q);
  wire [qos_pkg::Q_W-1:0] q_l3  = qos_pkg::l3_queue(prec, p0q);
  wire [qos_pkg::Q_W-1:0] q_len = qos_pkg::len_queue(len_q);
  wire [qos_pkg::Q_W-1:0] q_auto = (src == qos_pkg::SRC_L2) ? q_l2 :
                                   (src == qos_pkg::SRC_L3) ? q_l3 : q_len;
  wire [qos_pkg::Q_W-1:0] queue = hit_q    ? cq_q   :
                                  i_qos_en ? q_auto : p0q;

  wire c_ok = (tc_q >= {8'h00, len_q});
  wire e_ok = (te_q >= {8'h00, len_q});
  wire cong_drop = i_congested & (queue < i_congest_floor);

  always_comb
  begin
    color    = qos_pkg::COL_GREEN;
    wait_tok = 1'b0;
    drop     = 1'b0;
    deb_c    = 1'b0;
    deb_e    = 1'b0;
    remark   = 1'b0;
    case (mode)
      qos_pkg::MTR_TB:
      begin
        if (c_ok)
          deb_c = 1'b1;
        else if (!i_police)
          wait_tok = 1'b1;
        else
        begin
          color  = qos_pkg::COL_RED;
          drop   = i_red_drop;
          remark = ~i_red_drop;
        end
      end
      qos_pkg::MTR_SRTCM:
      begin
        if (c_ok)
          deb_c = 1'b1;
        else if (e_ok)
        begin
          color = qos_pkg::COL_YELLOW;
          deb_e = 1'b1;
        end
        else
        begin
          color  = qos_pkg::COL_RED;
          drop   = i_red_drop;
          remark = ~i_red_drop;
        end
      end
      qos_pkg::MTR_TRTCM:
      begin
        if (!e_ok)
        begin
          color  = qos_pkg::COL_RED;
          drop   = i_red_drop;
          remark = ~i_red_drop;
        end
        else if (c_ok)
        begin
          deb_c = 1'b1;
          deb_e = 1'b1;
        end
        else
        begin
          color = qos_pkg::COL_YELLOW;
          deb_e = 1'b1;
        end
      end
      default:
      begin
        color = qos_pkg::COL_GREEN;
      end
    endcase
    if (cong_drop)
      drop = 1'b1;
  end

  wire go   = eval & ~wait_tok;
  wire fire = go & (drop | up_if.ready);
  wire sent = fire & ~drop;

  wire [qos_pkg::TOK_W-1:0] tc_b = tc_q - ((sent & deb_c) ? {8'h00, len_q} : 24'h000000);
  wire [qos_pkg::TOK_W-1:0] te_b = te_q - ((sent & deb_e) ? {8'h00, len_q} : 24'h000000);

  wire [qos_pkg::TOK_W:0]   c_sum = {1'b0, tc_b} + {9'h000, i_cir_inc};
  wire [qos_pkg::TOK_W-1:0] spill = (c_sum > {1'b0, i_cbs}) ?
                                    c_sum[qos_pkg::TOK_W-1:0] - i_cbs : 24'h000000;

  assign tc_d = qos_pkg::fill(tc_b, {8'h00, i_cir_inc}, i_cbs);
  assign te_d = (mode == qos_pkg::MTR_SRTCM) ? qos_pkg::fill(te_b, spill, i_xbs) :
                qos_pkg::fill(te_b, {8'h00, i_pir_inc}, i_xbs);

  assign up_if.valid      = go & ~drop;
  assign up_if.data.queue = queue;
  assign up_if.data.color = color;
  assign up_if.data.dscp  = remark ? i_remark_dscp : dscp;
  assign up_if.data.len   = len_q;

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      qos_pkg::ST_IDLE:
      begin
        if (accept)
          st_d = qos_pkg::ST_EVAL;
      end
      qos_pkg::ST_EVAL:
      begin
        if (fire)
          st_d = qos_pkg::ST_IDLE;
      end
      default:
      begin
        st_d = qos_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st_q   <= qos_pkg::ST_IDLE;
      rdy_q  <= 1'b0;
      drop_q <= 1'b0;
      wait_q <= 1'b0;
    end
    else if (i_ce)
    begin
      st_q   <= st_d;
      rdy_q  <= (st_d == qos_pkg::ST_IDLE);
      drop_q <= fire & drop;
      wait_q <= eval & wait_tok;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      tc_q <= qos_pkg::TOK_RST;
      te_q <= qos_pkg::TOK_RST;
    end
    else if (i_ce)
    begin
      tc_q <= tc_d;
      te_q <= te_d;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_ce && accept)
    begin
      len_q  <= i_in_len;
      upri_q <= i_in_upri;
      tos_q  <= i_in_tos;
      hit_q  <= i_in_class_hit;
      cq_q   <= i_in_class_queue;
    end
  end

  desc_buf u_buf (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_ce  (i_ce),
    .up    (up_if),
    .dn    (dn_if)
  );

  assign dn_if.ready = i_out_ready;
  assign o_in_ready  = rdy_q;
  assign o_out_valid = dn_if.valid;
  assign o_out_queue = dn_if.data.queue;
  assign o_out_color = dn_if.data.color;
  assign o_out_dscp  = dn_if.data.dscp;
  assign o_out_len   = dn_if.data.len;
  assign o_drop      = drop_q;
  assign o_wait      = wait_q;
  assign o_tc_tokens = tc_q;
  assign o_te_tokens = te_q;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  wire unc = eval & i_qos_en & ~hit_q;

  sequence s_accept;
    i_in_valid && o_in_ready && i_ce;
  endsequence
  sequence s_starved;
    eval && mode == qos_pkg::MTR_TB && !i_police && tc_q < {8'h00, len_q};
  endsequence
  sequence s_tb_send;
    sent && deb_c && mode == qos_pkg::MTR_TB && i_ce;
  endsequence

  property p_accept;
    s_accept |=> eval && !o_in_ready;
  endproperty
  a_accept: assert property (p_accept) else $error("accepted word not held");

  property p_prec3;
    unc && src == qos_pkg::SRC_L3 && tos_q[7:5] == 3'h3 |-> queue == 3'h5;
  endproperty
  a_prec3: assert property (p_prec3) else $error("precedence 3 not queue 5");

  property p_prec7;
    unc && src == qos_pkg::SRC_L3 && tos_q[7:5] == 3'h7 |-> queue == 3'h7;
  endproperty
  a_prec7: assert property (p_prec7) else $error("precedence 7 not queue 7");

  property p_hit;
    eval && hit_q |-> queue == cq_q;
  endproperty
  a_hit: assert property (p_hit) else $error("classified packet remapped");

  property p_l2;
    unc && src == qos_pkg::SRC_L2 && upri_q == 3'h1 |-> queue == 3'h0;
  endproperty
  a_l2: assert property (p_l2) else $error("user priority 1 not queue 0");

  property p_len;
    unc && src == qos_pkg::SRC_LEN && len_q < 16'h00fa |-> queue == 3'h5;
  endproperty
  a_len: assert property (p_len) else $error("short packet not queue 5");

  property p_p0;
    unc && src == qos_pkg::SRC_L3 && prec == 3'h0 && !i_prec0_alt |-> queue == 3'h2;
  endproperty
  a_p0: assert property (p_p0) else $error("precedence 0 not queue 2");

  property p_cong;
    fire && i_congested && queue < i_congest_floor && i_ce |=> o_drop && !$past(up_if.valid);
  endproperty
  a_cong: assert property (p_cong) else $error("low queue kept under congestion");

  property p_cap;
    $past(i_ce) |-> tc_q <= $past(i_cbs);
  endproperty
  a_cap: assert property (p_cap) else $error("committed credit above size");

  property p_stall;
    s_starved |-> !fire && !up_if.valid;
  endproperty
  a_stall: assert property (p_stall) else $error("shaped packet sent short");

  property p_debit;
    s_tb_send |=> {1'b0, tc_q} + $past(len_q) <= $past({1'b0, tc_q}) + $past(i_cir_inc);
  endproperty
  a_debit: assert property (p_debit) else $error("send did not debit length");

  property p_remark;
    up_if.valid && up_if.data.color == qos_pkg::COL_RED && !cong_drop |->
      up_if.data.dscp == i_remark_dscp;
  endproperty
  a_remark: assert property (p_remark) else $error("red packet not remarked");

  property p_sr_red;
    eval && mode == qos_pkg::MTR_SRTCM && !c_ok && !e_ok |->
      color == qos_pkg::COL_RED && !deb_c && !deb_e;
  endproperty
  a_sr_red: assert property (p_sr_red) else $error("single-rate red wrong");

  property p_sr_yel;
    sent && mode == qos_pkg::MTR_SRTCM && color == qos_pkg::COL_YELLOW && i_ce |=>
      tc_q >= $past(tc_q);
  endproperty
  a_sr_yel: assert property (p_sr_yel) else $error("yellow debited committed");

  property p_tr_red;
    eval && mode == qos_pkg::MTR_TRTCM && !e_ok |->
      color == qos_pkg::COL_RED && !deb_c && !deb_e;
  endproperty
  a_tr_red: assert property (p_tr_red) else $error("two-rate red wrong");

  property p_tr_yel;
    eval && mode == qos_pkg::MTR_TRTCM && e_ok && !c_ok |->
      color == qos_pkg::COL_YELLOW && deb_e && !deb_c;
  endproperty
  a_tr_yel: assert property (p_tr_yel) else $error("two-rate yellow wrong");

endmodule : qos_priority_mapper_policer

// ---- sim/fwd_model.sv ----
/*
  forwarding-logic model that offers packet descriptors to the qos block.
  assumes one shared clock; caller starts a send just after a rising edge.
*/
`timescale 1ns/1ps
module fwd_model (
  input  wire logic        i_clk,
  input  wire logic        i_ready,
  output logic             o_valid,
  output logic [15:0]      o_len,
  output logic [2:0]       o_upri,
  output logic [7:0]       o_tos,
  output logic             o_hit,
  output logic [2:0]       o_cq
);
  initial
  begin
    o_valid = 1'b0;
    {o_len, o_upri, o_tos, o_hit, o_cq} = 31'h0;
  end

  // hold the offer until taken, then scramble the released lines
  task automatic send(input logic [30:0] d);
    logic r;
    o_valid = 1'b1;
    {o_len, o_upri, o_tos, o_hit, o_cq} = d;
    do
    begin
      r = i_ready;
      @(posedge i_clk);
      #10;
    end
    while (r !== 1'b1);
    o_valid = 1'b0;
    {o_len, o_upri, o_tos, o_hit, o_cq} = ~d;
  endtask : send
endmodule : fwd_model

// ---- sim/tb_qos_priority_mapper_policer.sv ----
/*
  self-checking bench for the qos mapper and policer.
  assumes fwd_model on the input side and a bench-driven scheduler ready.
*/
`timescale 1ns/1ps
module tb_qos_priority_mapper_policer;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        qen = 1'b1;
  logic        p0a = 1'b0;
  logic        pol = 1'b0;
  logic        rdrop = 1'b1;
  logic        cong = 1'b0;
  logic        ordy = 1'b1;
  logic [1:0]  src = 2'h0;
  logic [1:0]  mode = 2'h0;
  logic [2:0]  flr = 3'h0;
  logic [5:0]  rmk = 6'h2a;
  logic [15:0] cir = 16'h0000;
  logic [15:0] pir = 16'h0000;
  logic [23:0] cbs = 24'h0003e8;
  logic [23:0] xbs = 24'h0001f4;
  logic        iv, ir, hit, ov, drp, wt;
  logic [15:0] ilen, olen, rl;
  logic [2:0]  up, cq, oq;
  logic [7:0]  tos;
  logic [1:0]  oc;
  logic [5:0]  od;
  logic [23:0] tc, te, r;
  logic [23:0] rq[$];
  int          failures = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  localparam logic [23:0] DROP = 24'h000800;
  localparam logic [23:0] L2Q = {3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h1, 3'h0, 3'h2};
  localparam logic [23:0] L3Q = {3'h7, 3'h7, 3'h6, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2};
  localparam logic [63:0] LENS = {16'h00f9, 16'h00fa, 16'h044c, 16'h044d};
  localparam logic [11:0] LQ = {3'h5, 3'h3, 3'h3, 3'h2};

  fwd_model u_fwd (.i_clk(clk), .i_ready(ir), .o_valid(iv), .o_len(ilen), .o_upri(up),
                   .o_tos(tos), .o_hit(hit), .o_cq(cq));

  qos_priority_mapper_policer u_dut (
    .i_clk(clk), .i_rst(rst), .i_ce(ce), .i_in_valid(iv), .o_in_ready(ir),
    .i_in_len(ilen), .i_in_upri(up), .i_in_tos(tos), .i_in_class_hit(hit),
    .i_in_class_queue(cq), .i_qos_en(qen), .i_auto_src(src), .i_prec0_alt(p0a),
    .i_meter_mode(mode), .i_police(pol), .i_red_drop(rdrop), .i_remark_dscp(rmk),
    .i_cir_inc(cir), .i_pir_inc(pir), .i_cbs(cbs), .i_xbs(xbs), .i_congested(cong),
    .i_congest_floor(flr), .o_out_valid(ov), .i_out_ready(ordy), .o_out_queue(oq),
    .o_out_color(oc), .o_out_dscp(od), .o_out_len(olen), .o_drop(drp), .o_wait(wt),
    .o_tc_tokens(tc), .o_te_tokens(te));

  always #50 clk = ~clk;

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      stop_test();
    end
  end

  // results seen mid-cycle: accepted words and discards
  always @(negedge clk)
  begin
    if (ov === 1'b1 && ordy === 1'b1)
    begin
      rq.push_back({13'h0, oq, oc, od});
      rl = olen;
    end
    if (drp === 1'b1)
      rq.push_back(DROP);
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask : cyc_n

  function automatic logic [23:0] ex(input logic [2:0] q, input logic [1:0] c,
                                     input logic [5:0] d);
    return {13'h0, q, c, d};
  endfunction : ex

  task automatic pop();
    int n;
    n = 0;
    while (rq.size() == 0 && n < 50)
    begin
      cyc_n(1);
      n++;
    end
    r = (rq.size() > 0) ? rq.pop_front() : 24'hffffff;
  endtask : pop

  task automatic pkt(input logic [15:0] l, input logic [2:0] u, input logic [7:0] t,
                     input logic h, input logic [2:0] q);
    u_fwd.send({l, u, t, h, q});
    pop();
  endtask : pkt

  task automatic do_reset();
    rst = 1'b1;
    cyc_n(20);
    rst = 1'b0;
    cyc_n(2);
  endtask : do_reset

  task automatic fill(input logic [15:0] c, input logic [15:0] p, input int n);
    cir = c;
    pir = p;
    cyc_n(n);
    cir = 16'h0000;
    pir = 16'h0000;
    cyc_n(2);
  endtask : fill

  task automatic t_map();
    for (int i = 0; i < 8; i++)
    begin
      pkt(16'h0040, 3'(i), 8'h00, 1'b0, 3'h0);
      chk(r, ex(L2Q[3*i +: 3], 2'h0, 6'h00));
    end
    src = 2'h1;
    for (int i = 0; i < 8; i++)
    begin
      pkt(16'h0040, 3'h0, {3'(i), 5'h17}, 1'b0, 3'h0);
      chk(r, ex(L3Q[3*i +: 3], 2'h0, {3'(i), 3'h5}));
    end
    p0a = 1'b1;
    pkt(16'h0040, 3'h0, 8'h03, 1'b0, 3'h0);
    chk(r, ex(3'h0, 2'h0, 6'h00));
    p0a = 1'b0;
    pkt(16'h0040, 3'h7, 8'he0, 1'b1, 3'h6);
    chk(r, ex(3'h6, 2'h0, 6'h38));
    qen = 1'b0;
    pkt(16'h0040, 3'h7, 8'he0, 1'b0, 3'h0);
    chk(r, ex(3'h2, 2'h0, 6'h38));
    qen = 1'b1;
    src = 2'h2;
    for (int i = 0; i < 4; i++)
    begin
      pkt(LENS[16*i +: 16], 3'h0, 8'h00, 1'b0, 3'h0);
      chk(r, ex(LQ[3*i +: 3], 2'h0, 6'h00));
      chk({8'h0, rl}, {8'h0, LENS[16*i +: 16]});
    end
    src = 2'h0;
    cong = 1'b1;
    flr = 3'h3;
    pkt(16'h0040, 3'h0, 8'h00, 1'b0, 3'h0);
    chk(r, DROP);
    pkt(16'h0040, 3'h3, 8'h00, 1'b0, 3'h0);
    chk(r, ex(3'h3, 2'h0, 6'h00));
    cong = 1'b0;
    $display("done t_map");
  endtask : t_map

  task automatic t_bucket();
    do_reset();
    mode = 2'h1;
    ce = 1'b0;
    fill(16'h0064, 16'h0000, 5);
    chk(tc, 24'h0);
    ce = 1'b1;
    fill(16'h0064, 16'h0000, 15);
    chk(tc, 24'h0003e8);
    pkt(16'h0258, 3'h0, 8'h00, 1'b0, 3'h0);
    chk(r, ex(3'h2, 2'h0, 6'h00));
    chk(tc, 24'h000190);
    u_fwd.send({16'h0258, 3'h0, 8'h00, 1'b0, 3'h0});
    cyc_n(4);
    chk({23'h0, wt}, 24'h1);
    chk(24'(rq.size()), 24'h0);
    fill(16'h0064, 16'h0000, 8);
    pop();
    chk(r, ex(3'h2, 2'h0, 6'h00));
    do_reset();
    fill(16'h0064, 16'h0000, 15);
    pol = 1'b1;
    pkt(16'h04b0, 3'h0, 8'h00, 1'b0, 3'h0);
    chk(r, DROP);
    rdrop = 1'b0;
    pkt(16'h04b0, 3'h0, 8'hb8, 1'b0, 3'h0);
    chk(r, ex(3'h2, 2'h2, 6'h2a));
    chk(tc, 24'h0003e8);
    rdrop = 1'b1;
    pol = 1'b0;
    $display("done t_bucket");
  endtask : t_bucket

  task automatic t_srtcm();
    do_reset();
    mode = 2'h2;
    fill(16'h0064, 16'h0000, 25);
    chk(te, 24'h0001f4);
    pkt(16'h0320, 3'h0, 8'h00, 1'b0, 3'h0);
    chk(r, ex(3'h2, 2'h0, 6'h00));
    chk(tc, 24'h0000c8);
    pkt(16'h0190, 3'h0, 8'h00, 1'b0, 3'h0);
    chk(r, ex(3'h2, 2'h1, 6'h00));
    chk({tc[11:0], te[11:0]}, 24'h0c8064);
    pkt(16'h012c, 3'h0, 8'h00, 1'b0, 3'h0);
    chk(r, DROP);
    chk({tc[11:0], te[11:0]}, 24'h0c8064);
    $display("done t_srtcm");
  endtask : t_srtcm

  task automatic t_trtcm();
    do_reset();
    mode = 2'h3;
    cbs = 24'h0001f4;
    xbs = 24'h0003e8;
    fill(16'h0064, 16'h0064, 15);
    chk({tc[11:0], te[11:0]}, 24'h1f43e8);
    pkt(16'h0258, 3'h0, 8'h00, 1'b0, 3'h0);
    chk(r, ex(3'h2, 2'h1, 6'h00));
    chk({tc[11:0], te[11:0]}, 24'h1f4190);
    pkt(16'h012c, 3'h0, 8'h00, 1'b0, 3'h0);
    chk(r, ex(3'h2, 2'h0, 6'h00));
    chk({tc[11:0], te[11:0]}, 24'h0c8064);
    pkt(16'h00c8, 3'h0, 8'h00, 1'b0, 3'h0);
    chk(r, DROP);
    chk({tc[11:0], te[11:0]}, 24'h0c8064);
    $display("done t_trtcm");
  endtask : t_trtcm

  task automatic t_skid();
    do_reset();
    mode = 2'h0;
    ordy = 1'b0;
    for (int i = 3; i < 6; i++)
    begin
      u_fwd.send({16'h0040, 3'(i), 8'h00, 1'b0, 3'h0});
      cyc_n(1);
    end
    cyc_n(8);
    chk({23'h0, ir}, 24'h0);
    chk(24'(rq.size()), 24'h0);
    ordy = 1'b1;
    for (int i = 3; i < 6; i++)
    begin
      pop();
      chk(r, ex(3'(i), 2'h0, 6'h00));
    end
    $display("done t_skid");
  endtask : t_skid

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  initial
  begin
    do_reset();
    chk({tc[11:0], te[11:0]}, 24'h0);
    t_map();
    t_bucket();
    t_srtcm();
    t_trtcm();
    t_skid();
    stop_test();
  end
endmodule : tb_qos_priority_mapper_policer
